// ==== servo_seq_map.svh ====
// Offsets, reset values, display codes and timing figures of the sequence block
`ifndef SERVO_SEQ_MAP_SVH
`define SERVO_SEQ_MAP_SVH

`define CLK_PERIOD_NS 100
`define SCAN_TIME_NS 1000000
`define READY_TIME_MS 2000
`define BLINK_TIME_MS 500

`define OFS_FORCE 12'h000
`define OFS_INPUTS 12'h004
`define OFS_DRIVE 12'h008
`define OFS_STATUS 12'h00c

`define FORCE_RESET 22'h000000
`define STATUS_ALARM_BIT 0

`define DISP_CHAR_A 8'h41
`define DISP_CHAR_L 8'h4c
`define DISP_CHAR_DASH 8'h2d
`define DISP_CHAR_BLANK 8'h20

`endif

// ==== servo_seq_pkg.sv ====
// Types shared by the sequence input priority block
`default_nettype none
package servo_seq_pkg;

    typedef struct packed {
        logic freeRun;
        logic servoOn;
        logic forcedStop;
        logic brakeOverheat;
        logic torqueLimit1;
        logic torqueLimit0;
        logic forwardOvertravelLimit;
        logic reverseOvertravelLimit;
        logic pulseInhibit;
        logic pause;
        logic posCancel;
        logic devClear;
        logic manualForwardCmd;
        logic manualReverseCmd;
        logic startPos;
        logic homing;
        logic homeLimitSw;
        logic interruptIn;
        logic posPreset;
        logic alarmReset;
        logic editPermit;
        logic torqueCmd;
    } seq_in_t;

    typedef struct packed {
        logic powerOn;
        logic decelStop;
        logic [1:0] torqueLimitSel;
        logic torqueCmdActive;
        logic forwardRun;
        logic reverseRun;
        logic startPosGo;
        logic homingGo;
        logic motionHold;
        logic posCancelGo;
        logic devClearGo;
        logic homeLimitHit;
        logic interruptHit;
        logic presetGo;
        logic editEnabled;
    } drive_out_t;

    typedef struct packed {
        logic [7:0] char2;
        logic [7:0] char1;
        logic [7:0] char0;
        logic blinkOn;
        logic ledOrange;
    } disp_t;

    typedef enum logic [3:0] {
        PWR_OFF = 4'b0001,
        PWR_DIAG = 4'b0010,
        PWR_READY = 4'b0100,
        PWR_FAIL = 4'b1000
    } power_state_t;

    typedef struct packed {
        power_state_t pwr;
        logic [15:0] scanCnt;
        logic [15:0] readyCnt;
        logic [15:0] blinkCnt;
        logic blinkPhase;
        seq_in_t inSample;
        logic [21:0] forceMask;
        logic alarmLatch;
        logic diagFailed;
        drive_out_t drive;
        disp_t disp;
        logic servoCtrlReady;
        logic servoOnReady;
        logic wrPend;
        logic [11:0] wrAddr;
        logic [31:0] rdata;
        logic hreadyout;
    } state_t;

endpackage
`default_nettype wire

// ==== servo_input_priority_ready.sv ====
// Sequence input priority resolver, servo-control-ready timer, alarm display and AHB-Lite slave
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`include "servo_seq_map.svh"
`default_nettype none
module servo_input_priority_ready #(
    parameter int SCAN_CYCLES = `SCAN_TIME_NS / `CLK_PERIOD_NS,
    parameter int READY_TICKS = `READY_TIME_MS * 1000000 / `SCAN_TIME_NS,
    parameter int BLINK_TICKS = `BLINK_TIME_MS * 1000000 / `SCAN_TIME_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sequence input terminals
    input wire servo_seq_pkg::seq_in_t seqIn,
    // Supply, diagnosis and motor status
    input wire logic ctrlPowerOk,
    input wire logic mainPowerOk,
    input wire logic selfDiagPass,
    input wire logic faultDetect,
    input wire logic motorMoving,
    // Resolved drive commands
    output servo_seq_pkg::drive_out_t driveOut,
    output logic servoCtrlReady,
    output logic servoOnReady,
    // Keypad display and LED
    output servo_seq_pkg::disp_t dispOut,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import servo_seq_pkg::*;

    state_t cur;
    state_t next_cur;

    // A go term passes only while power is on and no higher class blocks it
    function automatic logic gateGo(input logic go, input logic block, input logic on);
        gateGo = go & ~block & on;
    endfunction

    // Byte offset must be word aligned and inside the small window
    function automatic logic hitReg(input logic [31:0] addr, input logic [11:0] ofs);
        hitReg = (addr[31:12] == 20'h00000) && (addr[11:0] == ofs);
    endfunction

    // Shared step of the scan, ready and blink counters
    function automatic logic [15:0] bump(input logic [15:0] c);
        bump = c + 16'h0001;
    endfunction

    // Terminal count of a counter running from 0 to n-1
    function automatic logic atLast(input logic [15:0] c, input int n);
        atLast = (c == 16'(n - 1));
    endfunction

    seq_in_t eff;
    logic scanTick;
    logic class1Stop;
    logic class2Stop;
    logic commonHold;
    logic forwardBlock;
    logic reverseBlock;
    logic startBlock;
    logic homeBlock;
    logic runOn;
    logic manualBoth;
    logic addrPhase;
    logic alarmSet;
    logic alarmClr;

    always_comb begin
        next_cur = cur;
        eff = seq_in_t'(cur.inSample | seq_in_t'(cur.forceMask));
        scanTick = atLast(cur.scanCnt, SCAN_CYCLES);
        class1Stop = 1'b0;
        class2Stop = 1'b0;
        commonHold = 1'b0;
        forwardBlock = 1'b0;
        reverseBlock = 1'b0;
        startBlock = 1'b0;
        homeBlock = 1'b0;
        runOn = 1'b0;
        manualBoth = 1'b0;
        addrPhase = 1'b0;
        alarmSet = 1'b0;
        alarmClr = 1'b0;

        // Terminal scan; a pulse shorter than one scan may be missed
        if (scanTick) begin
            next_cur.scanCnt = 16'h0000;
            next_cur.inSample = seqIn;
        end else begin
            next_cur.scanCnt = bump(cur.scanCnt);
        end

        // Power-up self-diagnosis and ready timer
        case (cur.pwr)
            PWR_OFF: begin
                next_cur.readyCnt = 16'h0000;
                if (ctrlPowerOk && mainPowerOk) begin
                    next_cur.pwr = PWR_DIAG;
                end
            end
            PWR_DIAG: begin
                if (!(ctrlPowerOk && mainPowerOk)) begin
                    next_cur.pwr = PWR_OFF;
                end else if (scanTick) begin
                    if (atLast(cur.readyCnt, READY_TICKS)) begin
                        if (selfDiagPass) begin
                            next_cur.pwr = PWR_READY;
                            next_cur.servoCtrlReady = 1'b1;
                        end else begin
                            next_cur.pwr = PWR_FAIL;
                            next_cur.diagFailed = 1'b1;
                        end
                    end else begin
                        next_cur.readyCnt = bump(cur.readyCnt);
                    end
                end
            end
            PWR_READY: begin
                // Held until the power-on reset; supply dips do not drop it
                next_cur.servoCtrlReady = 1'b1;
            end
            PWR_FAIL: begin
                // Stays failed until the power-on reset; supply changes do not leave it; the alarm tells the host why
                next_cur.servoCtrlReady = 1'b0;
            end
            default: begin
                next_cur.pwr = PWR_OFF;
            end
        endcase

        // Alarm latch: fault or failed diagnosis sets, reset terminal or software clears
        alarmSet = faultDetect | cur.diagFailed;
        // Alarm reset only touches the latch, never the motor path
        alarmClr = eff.alarmReset;

        // Class one and two stop conditions
        class1Stop = eff.freeRun | ~eff.servoOn | cur.alarmLatch | ~cur.servoCtrlReady;
        class2Stop = eff.forcedStop | eff.brakeOverheat;

        // Class four stopping inputs shared by every motion go
        commonHold = class2Stop | eff.pulseInhibit | eff.pause | eff.posCancel | eff.devClear;
        forwardBlock = commonHold | eff.forwardOvertravelLimit;
        reverseBlock = commonHold | eff.reverseOvertravelLimit;
        startBlock = commonHold | eff.forwardOvertravelLimit | eff.reverseOvertravelLimit;
        // Homing uses the overtravels to find home, so only the other stops hold it
        homeBlock = commonHold;

        // Power stage, resolved every cycle
        if (eff.freeRun) begin
            // Output cut at once, whatever else is active
            next_cur.drive.powerOn = 1'b0;
            next_cur.drive.decelStop = 1'b0;
        end else if (class1Stop) begin
            // Servo-off while turning decelerates first, then coasts
            if (cur.drive.powerOn && motorMoving) begin
                next_cur.drive.powerOn = 1'b1;
                next_cur.drive.decelStop = 1'b1;
            end else begin
                next_cur.drive.powerOn = 1'b0;
                next_cur.drive.decelStop = 1'b0;
            end
        end else begin
            next_cur.drive.powerOn = 1'b1;
            // Forced stop and overheat decelerate with the servo kept on
            next_cur.drive.decelStop = class2Stop;
        end

        runOn = ~class1Stop & ~eff.freeRun;

        // Torque limit ignores overtravel and lower classes
        next_cur.drive.torqueLimitSel = runOn ? {eff.torqueLimit1, eff.torqueLimit0} : 2'b00;
        // Forced stop overrides a torque command
        next_cur.drive.torqueCmdActive = gateGo(eff.torqueCmd, class2Stop, runOn);

        // Motion class; opposing manual commands cancel each other
        manualBoth = eff.manualForwardCmd & eff.manualReverseCmd;
        // Forward overtravel wins over manual forward
        next_cur.drive.forwardRun = gateGo(eff.manualForwardCmd, forwardBlock | manualBoth, runOn);
        next_cur.drive.reverseRun = gateGo(eff.manualReverseCmd, reverseBlock | manualBoth, runOn);
        next_cur.drive.startPosGo = gateGo(eff.startPos, startBlock | eff.homing, runOn);
        next_cur.drive.homingGo = gateGo(eff.homing, homeBlock, runOn);

        // Stop class outputs themselves pass whenever class one and two allow
        next_cur.drive.motionHold = runOn & (eff.pulseInhibit | eff.pause);
        next_cur.drive.posCancelGo = gateGo(eff.posCancel, class2Stop, runOn);
        next_cur.drive.devClearGo = gateGo(eff.devClear, class2Stop, runOn);

        // Home limit acts only during a running homing; interrupt acts without homing, preset is held off by homing
        next_cur.drive.homeLimitHit = gateGo(eff.homeLimitSw, homeBlock, runOn & eff.homing);
        next_cur.drive.interruptHit = gateGo(eff.interruptIn, homeBlock, runOn);
        next_cur.drive.presetGo = gateGo(eff.posPreset, commonHold | eff.homing, runOn);

        // Edit permission has no path into the motor logic
        next_cur.drive.editEnabled = eff.editPermit;

        // Ready for servo-on once the stage is on and not winding down
        next_cur.servoOnReady = runOn & cur.drive.powerOn & ~cur.drive.decelStop;

        // Blink timer, free running in scan ticks
        if (scanTick) begin
            if (atLast(cur.blinkCnt, BLINK_TICKS)) begin
                next_cur.blinkCnt = 16'h0000;
                next_cur.blinkPhase = ~cur.blinkPhase;
            end else begin
                next_cur.blinkCnt = bump(cur.blinkCnt);
            end
        end

        // Alarm display
        if (cur.alarmLatch) begin
            next_cur.disp.char2 = `DISP_CHAR_A;
            next_cur.disp.char1 = `DISP_CHAR_L;
            next_cur.disp.char0 = `DISP_CHAR_DASH;
            next_cur.disp.blinkOn = cur.blinkPhase;
            next_cur.disp.ledOrange = cur.blinkPhase;
        end else begin
            next_cur.disp.char2 = `DISP_CHAR_BLANK;
            next_cur.disp.char1 = `DISP_CHAR_BLANK;
            next_cur.disp.char0 = `DISP_CHAR_BLANK;
            next_cur.disp.blinkOn = 1'b0;
            next_cur.disp.ledOrange = 1'b0;
        end

        // Bus data phase: writes land one cycle after their address phase
        next_cur.wrPend = 1'b0;
        if (cur.wrPend) begin
            if (cur.wrAddr == `OFS_FORCE) begin
                next_cur.forceMask = hwdata[21:0];
            end else if (cur.wrAddr == `OFS_STATUS) begin
                alarmClr = alarmClr | hwdata[`STATUS_ALARM_BIT];
            end
        end

        // A new fault in the clearing cycle is kept
        if (alarmSet) begin
            next_cur.alarmLatch = 1'b1;
        end else if (alarmClr) begin
            next_cur.alarmLatch = 1'b0;
        end

        // Address phase: zero wait states, read data registered for the data phase
        addrPhase = hsel & hready & htrans[1];
        next_cur.hreadyout = 1'b1;
        if (addrPhase) begin
            if (hwrite) begin
                next_cur.wrPend = 1'b1;
                next_cur.wrAddr = haddr[11:0];
                next_cur.rdata = 32'h00000000;
            end else if (hitReg(haddr, `OFS_FORCE)) begin
                next_cur.rdata = {10'h000, cur.forceMask};
            end else if (hitReg(haddr, `OFS_INPUTS)) begin
                next_cur.rdata = {10'h000, cur.inSample};
            end else if (hitReg(haddr, `OFS_DRIVE)) begin
                next_cur.rdata = {16'h0000, cur.drive};
            end else if (hitReg(haddr, `OFS_STATUS)) begin
                next_cur.rdata = {24'h000000, cur.pwr, cur.diagFailed, cur.servoOnReady,
                                  cur.servoCtrlReady, cur.alarmLatch};
            end else begin
                next_cur.rdata = 32'h00000000;
            end
            // Writes outside the window park on an unused offset and land nowhere
            if (hwrite && (haddr[31:12] != 20'h00000)) begin
                next_cur.wrAddr = 12'hfff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cur <= '0;
            cur.pwr <= PWR_OFF;
            cur.forceMask <= `FORCE_RESET;
            // Bus must see ready even while held in reset
            cur.hreadyout <= 1'b1;
            cur.disp.char2 <= `DISP_CHAR_BLANK;
            cur.disp.char1 <= `DISP_CHAR_BLANK;
            cur.disp.char0 <= `DISP_CHAR_BLANK;
        end else begin
            cur <= next_cur;
        end
    end

    assign driveOut = cur.drive;
    assign servoCtrlReady = cur.servoCtrlReady;
    assign servoOnReady = cur.servoOnReady;
    assign dispOut = cur.disp;
    assign hreadyout = cur.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = cur.rdata;

endmodule
`default_nettype wire

// ==== host_seq_model.sv ====
// Host controller model that drives the sequence terminals as held levels
`default_nettype none
module host_seq_model (
    // Clock
    input wire logic clk,
    // Level requested by the test sequence
    input wire servo_seq_pkg::seq_in_t cmd,
    // Sequence terminals
    output var servo_seq_pkg::seq_in_t seqIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import servo_seq_pkg::*;

    initial seqIn = '0;

    // Levels move only after an edge and follow cmd every cycle; pulse length is set by the test
    always @(posedge clk) begin
        seqIn <= cmd;
    end
endmodule
`default_nettype wire

// ==== servo_seq_checker.sv ====
// Port-level assertions for the sequence priority and ready block
`default_nettype none
module servo_seq_checker #(
    parameter int SCAN_CYCLES = 4,
    parameter int READY_TICKS = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Watched ports
    input wire servo_seq_pkg::seq_in_t seqIn,
    input wire logic ctrlPowerOk,
    input wire logic mainPowerOk,
    input wire logic selfDiagPass,
    input wire servo_seq_pkg::drive_out_t driveOut,
    input wire logic servoCtrlReady,
    input wire logic servoOnReady,
    input wire servo_seq_pkg::disp_t dispOut
);
    import servo_seq_pkg::*;
    localparam int LAT = SCAN_CYCLES + 2;
    logic [7:0] freeCnt;
    logic [7:0] overtravelCnt;
    logic [7:0] stopCnt;
    logic [31:0] supCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    function automatic logic [7:0] sat(input logic [7:0] c);
        return (c == 8'hff) ? c : c + 8'h01;
    endfunction

    // Held-level counters; a level matters only once a scan has seen it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            freeCnt <= 8'h00;
            overtravelCnt <= 8'h00;
            stopCnt <= 8'h00;
            supCnt <= 32'h0;
        end else begin
            freeCnt <= seqIn.freeRun ? sat(freeCnt) : 8'h00;
            overtravelCnt <= seqIn.forwardOvertravelLimit ? sat(overtravelCnt) : 8'h00;
            stopCnt <= seqIn.forcedStop ? sat(stopCnt) : 8'h00;
            supCnt <= (ctrlPowerOk && mainPowerOk) ? supCnt + 32'h1 : 32'h0;
        end
    end

    sequence s_rise;
        !servoCtrlReady ##1 servoCtrlReady;
    endsequence

    property p_free_run_off;
        freeCnt > 8'(LAT) |-> !driveOut.powerOn;
    endproperty
    property p_overtravel_block;
        overtravelCnt > 8'(LAT) |-> !driveOut.forwardRun;
    endproperty
    property p_stop_block;
        stopCnt > 8'(LAT) |-> !(driveOut.forwardRun || driveOut.reverseRun
            || driveOut.torqueCmdActive);
    endproperty
    property p_no_dual_run;
        !(driveOut.forwardRun && driveOut.reverseRun);
    endproperty
    property p_ready_holds;
        servoCtrlReady |=> servoCtrlReady;
    endproperty
    property p_ready_diag;
        s_rise |-> $past(selfDiagPass);
    endproperty
    property p_ready_delay;
        s_rise |-> supCnt >= 32'((READY_TICKS - 1) * SCAN_CYCLES);
    endproperty
    property p_alarm_disp;
        dispOut.ledOrange |-> dispOut.char2 == 8'h41 && dispOut.char1 == 8'h4c
            && dispOut.char0 == 8'h2d;
    endproperty
    property p_blink_pair;
        dispOut.blinkOn == dispOut.ledOrange;
    endproperty
    property p_servo_on_ready;
        servoOnReady |-> $past(driveOut.powerOn) && servoCtrlReady;
    endproperty

    a_free_run_off: assert property (p_free_run_off)
        else $error("power on under free-run");
    a_overtravel_block: assert property (p_overtravel_block)
        else $error("forward run past overtravel");
    a_stop_block: assert property (p_stop_block)
        else $error("motion under forced stop");
    a_no_dual_run: assert property (p_no_dual_run)
        else $error("both directions run");
    a_ready_holds: assert property (p_ready_holds)
        else $error("control ready dropped");
    a_ready_diag: assert property (p_ready_diag)
        else $error("ready without diagnosis");
    a_ready_delay: assert property (p_ready_delay)
        else $error("control ready too early");
    a_alarm_disp: assert property (p_alarm_disp)
        else $error("alarm prefix missing");
    a_blink_pair: assert property (p_blink_pair)
        else $error("display and led blink apart");
    a_servo_on_ready: assert property (p_servo_on_ready)
        else $error("servo-on ready unpowered");
endmodule

bind servo_input_priority_ready servo_seq_checker #(
    .SCAN_CYCLES(SCAN_CYCLES),
    .READY_TICKS(READY_TICKS)
) chk (
    .clk(clk),
    .rstn(rstn),
    .seqIn(seqIn),
    .ctrlPowerOk(ctrlPowerOk),
    .mainPowerOk(mainPowerOk),
    .selfDiagPass(selfDiagPass),
    .driveOut(driveOut),
    .servoCtrlReady(servoCtrlReady),
    .servoOnReady(servoOnReady),
    .dispOut(dispOut)
);
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the sequence priority and ready block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import servo_seq_pkg::*;
    localparam int SC = 4;
    localparam int RT = 3;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ctrlPowerOk = 1'b0;
    logic mainPowerOk = 1'b0;
    logic selfDiagPass = 1'b1;
    logic faultDetect = 1'b0;
    logic motorMoving = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    seq_in_t cmd = '0;
    seq_in_t seqIn;
    drive_out_t driveOut;
    disp_t dispOut;
    logic servoCtrlReady;
    logic servoOnReady;
    int fail_count = 0;
    int n_checks = 0;
    int n;
    int m;

    always #50 clk = ~clk;

    host_seq_model host (.clk(clk), .cmd(cmd), .seqIn(seqIn));

    servo_input_priority_ready #(.SCAN_CYCLES(SC), .READY_TICKS(RT), .BLINK_TICKS(2)) uut (
        .clk(clk), .rstn(rstn), .seqIn(seqIn),
        .ctrlPowerOk(ctrlPowerOk), .mainPowerOk(mainPowerOk), .selfDiagPass(selfDiagPass),
        .faultDetect(faultDetect), .motorMoving(motorMoving),
        .driveOut(driveOut), .servoCtrlReady(servoCtrlReady), .servoOnReady(servoOnReady),
        .dispOut(dispOut), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                check("bus wait", 32'h0, 32'h1);
                complete_run();
            end
            @(posedge clk);
        end
    endtask

    // Single whole-word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("bus response", {31'h0, hresp}, 32'h0);
    endtask

    // Host delay, worst-case scan, resolve and the ready stage behind it
    task automatic settle();
        repeat (SC + 4) @(posedge clk);
    endtask

    task automatic drive_case(input logic [21:0] v, input logic [15:0] msk, input logic [15:0] e);
        cmd <= v;
        settle();
        check($sformatf("drive for %h", v), {16'h0, driveOut & msk}, {16'h0, e});
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b0, 32'h00c, 32'h0);
        check("status after reset", rd, 32'h10);
        check("display idle", {6'h0, dispOut}, 32'h0080_8080);
        ctrlPowerOk <= 1'b1;
        mainPowerOk <= 1'b1;
        n = 0;
        while (servoCtrlReady !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check("ready not early", {31'h0, n >= (RT - 1) * SC}, 32'h1);
        check("ready not late", {31'h0, n <= (RT + 2) * SC}, 32'h1);
        if (n >= 100) begin
            complete_run();
        end
        ctrlPowerOk <= 1'b0;
        settle();
        check("ready holds", {31'h0, servoCtrlReady}, 32'h1);
        ctrlPowerOk <= 1'b1;
        cmd <= 22'h100000;
        settle();
        check("servo-on ready", {30'h0, driveOut.powerOn, servoOnReady}, 32'h3);
        drive_case(22'h100200, 16'h8400, 16'h8400);
        drive_case(22'h108200, 16'h0400, 16'h0000);
        drive_case(22'h128000, 16'h3000, 16'h2000);
        drive_case(22'h100300, 16'h0600, 16'h0000);
        drive_case(22'h180201, 16'h4c00, 16'h4000);
        drive_case(22'h380200, 16'h8400, 16'h0000);
        drive_case(22'h000200, 16'h8400, 16'h0000);
        drive_case(22'h104080, 16'h0100, 16'h0000);
        drive_case(22'h100078, 16'h008e, 16'h008c);
        drive_case(22'h100206, 16'h8401, 16'h8401);
        drive_case(22'h110000, 16'h3000, 16'h1000);
        drive_case(22'h140100, 16'h4200, 16'h4000);
        drive_case(22'h100181, 16'h0b00, 16'h0b00);
        drive_case(22'h103c58, 16'h00fe, 16'h0070);
        motorMoving <= 1'b1;
        drive_case(22'h000000, 16'hc000, 16'hc000);
        motorMoving <= 1'b0;
        settle();
        check("coast after stop", {16'h0, driveOut & 16'hc000}, 32'h0);
        cmd <= '0;
        bus(1'b1, 32'h000, 32'h0010_0200);
        settle();
        bus(1'b0, 32'h000, 32'h0);
        check("force readback", rd, 32'h0010_0200);
        bus(1'b0, 32'h008, 32'h0);
        check("drive register", rd & 32'h8400, 32'h8400);
        bus(1'b0, 32'h100, 32'h0);
        check("unmapped read", rd, 32'h0);
        cmd <= 22'h100000;
        bus(1'b1, 32'h000, 32'h0);
        faultDetect <= 1'b1;
        settle();
        faultDetect <= 1'b0;
        check("alarm prefix", {8'h0, dispOut[25:2]}, 32'h0041_4c2d);
        check("alarm power off", {31'h0, driveOut.powerOn}, 32'h0);
        n = 0;
        m = 0;
        repeat (24) begin
            @(posedge clk);
            if (dispOut.ledOrange === 1'b1) begin
                n++;
            end else begin
                m++;
            end
        end
        check("led blinks", {31'h0, n > 0 && m > 0}, 32'h1);
        bus(1'b1, 32'h00c, 32'h1);
        settle();
        check("alarm cleared", {8'h0, dispOut[25:2]}, 32'h0020_2020);
        // Second reset in mid-run with a failing self-test
        rstn <= 1'b0;
        selfDiagPass <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat ((RT + 3) * SC) @(posedge clk);
        check("no ready on failed test", {31'h0, servoCtrlReady}, 32'h0);
        check("test failure alarm", {8'h0, dispOut[25:2]}, 32'h0041_4c2d);
        complete_run();
    end
endmodule
`default_nettype wire
